// ### hdl/timer_compare_output_pwm.sv
// Timer compare-output and fast-PWM waveform stage with Avalon-MM registers
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module timer_compare_output_pwm
  import timer_pwm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_compare_out_a_pin,
  output logic o_compare_out_a_override,
  output logic o_compare_out_b_pin,
  output logic o_compare_out_b_override,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [1:0][15:0] cmp;
    logic [15:0] cnt;
    logic [9:0] psc;
    logic [1:0] oc;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] ien;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [3:0] waveform_gen_select;
  logic fast_pwm;
  logic toggle_mode;
  logic [15:0] top;
  logic [9:0] psc_last;
  logic running;
  logic tick;
  logic wrap;
  logic bus_req;
  logic wr_take;
  logic [1:0][1:0] action;
  logic [1:0] match;
  logic [1:0] override;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign waveform_gen_select = {state_r.cfg[WGM_HI_HI:0], state_r.ctrl[WGM_LO_HI:0]};
  assign fast_pwm = (waveform_gen_select == WGM_FAST_8) || (waveform_gen_select == WGM_FAST_9) ||
                    (waveform_gen_select == WGM_FAST_10) || (waveform_gen_select == WGM_FAST_FIXED) ||
                    (waveform_gen_select == WGM_FAST_A);
  assign toggle_mode = (waveform_gen_select == WGM_FAST_FIXED) || (waveform_gen_select == WGM_FAST_A);

  always_comb begin
    if (waveform_gen_select == WGM_FAST_8) begin
      top = TOP_8BIT;
    end else if (waveform_gen_select == WGM_FAST_9) begin
      top = TOP_9BIT;
    end else if (waveform_gen_select == WGM_FAST_10) begin
      top = TOP_10BIT;
    end else if ((waveform_gen_select == WGM_FAST_A) || (waveform_gen_select == WGM_CTC_A) ||
                 (waveform_gen_select == WGM_CTC_ALT)) begin
      top = state_r.cmp[0];
    end else begin
      top = TOP_MAX;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (state_r.cfg[PSC_SEL_HI:PSC_SEL_LO])
      3'h1: psc_last = PSC_LAST_1;
      3'h2: psc_last = PSC_LAST_8;
      3'h3: psc_last = PSC_LAST_32;
      3'h4: psc_last = PSC_LAST_64;
      3'h5: psc_last = PSC_LAST_128;
      3'h6: psc_last = PSC_LAST_256;
      default: psc_last = PSC_LAST_1024;
    endcase
  end

  assign running = !state_r.cfg[GATE_BIT] && (state_r.cfg[PSC_SEL_HI:PSC_SEL_LO] != 3'h0);
  assign tick = running && (state_r.psc == psc_last);
  assign wrap = tick && (state_r.cnt == top);

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      action[i] = state_r.ctrl[(CHAN_A_ACTION_HI - ACTION_FIELD_STEP * i) -: 2];
      match[i] = tick && (state_r.cnt == state_r.cmp[i]);
      override[i] = (action[i] != ACT_OFF) &&
                    !(fast_pwm && (action[i] == ACT_TOGGLE) && !((i == 0) && toggle_mode));
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign bus_req = i_avs_read || i_avs_write;
  assign wr_take = i_avs_write && state_r.ack;
  assign o_avs_waitrequest = bus_req && !state_r.ack;
  assign o_avs_readdata = state_r.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] sts_set;
    logic [IRQ_W-1:0] sts_clr;
    logic [15:0] wmask;
    sts_set = '0;
    sts_clr = '0;
    wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    state_nxt = state_r;
    state_nxt.ack = bus_req && !state_r.ack;
    state_nxt.rdata = 32'h0000_0000;
    if (i_avs_read && !state_r.ack) begin
      if (i_avs_address == ADDR_OUTPUT_MODE_CTRL) begin
        state_nxt.rdata = {24'h000000, state_r.ctrl};
      end else if (i_avs_address == ADDR_CLOCK_CFG) begin
        state_nxt.rdata = {24'h000000, state_r.cfg};
      end else if (i_avs_address == ADDR_COMPARE_VALUE_A) begin
        state_nxt.rdata = {16'h0000, state_r.cmp[0]};
      end else if (i_avs_address == ADDR_COMPARE_VALUE_B) begin
        state_nxt.rdata = {16'h0000, state_r.cmp[1]};
      end else if (i_avs_address == ADDR_COUNTER_VALUE) begin
        state_nxt.rdata = {16'h0000, state_r.cnt};
      end else if (i_avs_address == ADDR_IRQ_STATUS) begin
        state_nxt.rdata = {29'h00000000, state_r.sts};
      end else if (i_avs_address == ADDR_IRQ_ENABLE) begin
        state_nxt.rdata = {29'h00000000, state_r.ien};
      end
    end
    // Prescaler and counter
    if (!running) begin
      state_nxt.psc = 10'h000;
    end else if (tick) begin
      state_nxt.psc = 10'h000;
    end else begin
      state_nxt.psc = state_r.psc + 10'h001;
    end
    if (wrap) begin
      state_nxt.cnt = BOTTOM;
      sts_set[STS_OVF] = 1'b1;
    end else if (tick) begin
      state_nxt.cnt = state_r.cnt + 16'h0001;
    end
    // Waveform outputs
    for (int i = 0; i < 2; i++) begin
      if (match[i]) begin
        sts_set[STS_CMP_A + i] = 1'b1;
      end
      if (fast_pwm) begin
        if (action[i][1]) begin
          if (wrap) begin
            state_nxt.oc[i] = !action[i][0];
          end else if (match[i] && (state_r.cmp[i] != top)) begin
            state_nxt.oc[i] = action[i][0];
          end
        end else if ((action[i] == ACT_TOGGLE) && (i == 0) && toggle_mode && match[i]) begin
          state_nxt.oc[i] = !state_r.oc[i];
        end
      end else if (match[i]) begin
        case (action[i])
          ACT_TOGGLE: state_nxt.oc[i] = !state_r.oc[i];
          ACT_CLEAR: state_nxt.oc[i] = 1'b0;
          ACT_SET: state_nxt.oc[i] = 1'b1;
          default: state_nxt.oc[i] = state_r.oc[i];
        endcase
      end
    end
    // Register writes
    if (wr_take) begin
      if (i_avs_address == ADDR_OUTPUT_MODE_CTRL) begin
        if (i_avs_byteenable[0]) begin
          state_nxt.ctrl = i_avs_writedata[7:0] & CTRL_WRITE_MASK;
        end
      end else if (i_avs_address == ADDR_CLOCK_CFG) begin
        if (i_avs_byteenable[0]) begin
          state_nxt.cfg = i_avs_writedata[7:0] & CFG_WRITE_MASK;
        end
      end else if (i_avs_address == ADDR_COMPARE_VALUE_A) begin
        state_nxt.cmp[0] = (state_r.cmp[0] & ~wmask) | (i_avs_writedata[15:0] & wmask);
      end else if (i_avs_address == ADDR_COMPARE_VALUE_B) begin
        state_nxt.cmp[1] = (state_r.cmp[1] & ~wmask) | (i_avs_writedata[15:0] & wmask);
      end else if (i_avs_address == ADDR_COUNTER_VALUE) begin
        state_nxt.cnt = (state_r.cnt & ~wmask) | (i_avs_writedata[15:0] & wmask);
      end else if (i_avs_address == ADDR_IRQ_CLEAR) begin
        if (i_avs_byteenable[0]) begin
          sts_clr = i_avs_writedata[IRQ_W-1:0];
        end
      end else if (i_avs_address == ADDR_IRQ_ENABLE) begin
        if (i_avs_byteenable[0]) begin
          state_nxt.ien = i_avs_writedata[IRQ_W-1:0];
        end
      end
    end
    // Sticky status, set wins over clear
    state_nxt.sts = (state_r.sts & ~sts_clr) | sts_set;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_r <= '{ctrl: CTRL_RESET, cfg: CFG_RESET, cmp: {VALUE_RESET, VALUE_RESET}, cnt: VALUE_RESET,
                   psc: 10'h000, oc: 2'h0, sts: IRQ_RESET, ien: IRQ_RESET, ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_compare_out_a_pin = state_r.oc[0];
  assign o_compare_out_b_pin = state_r.oc[1];
  assign o_compare_out_a_override = override[0];
  assign o_compare_out_b_override = override[1];
  assign o_irq = |(state_r.sts & state_r.ien);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  AST_GATE_FREEZE: assert property (state_r.cfg[GATE_BIT] && !wr_take |=> $stable(state_r.cnt))
    else $error("counter moved while gated");
  AST_OVERRIDE_OFF: assert property (action[0] == ACT_OFF |-> !o_compare_out_a_override)
    else $error("channel A override with action off");
  AST_NONPWM_CLEAR: assert property (!fast_pwm && match[0] && action[0] == ACT_CLEAR |=> !o_compare_out_a_pin)
    else $error("non-PWM clear on match failed");
  AST_FAST_B_TOGGLE_OFF: assert property (fast_pwm && action[1] == ACT_TOGGLE |-> !o_compare_out_b_override)
    else $error("channel B connected in fast PWM toggle");
  AST_FAST_SET_AT_TOP: assert property (fast_pwm && wrap && action[0] == ACT_CLEAR |=> o_compare_out_a_pin)
    else $error("non-inverted output not set at TOP");
  AST_CMP_AT_TOP: assert property (fast_pwm && wrap && action[1] == ACT_SET && state_r.cmp[1] == top
                                   |=> !o_compare_out_b_pin)
    else $error("match at TOP not ignored");
  AST_WRAP_BOTTOM: assert property (fast_pwm && wrap && !wr_take |=> state_r.cnt == BOTTOM)
    else $error("counter did not clear after TOP");
  AST_OVF_FLAG: assert property (wrap |=> state_r.sts[STS_OVF])
    else $error("overflow flag not set at TOP");
  AST_TOP_8BIT: assert property (waveform_gen_select == WGM_FAST_8 |-> top == TOP_8BIT)
    else $error("wrong TOP in 8-bit fast PWM");
  AST_PSC_8: assert property (tick && state_r.cfg[PSC_SEL_HI:PSC_SEL_LO] == 3'h2 ##1
                              (running && state_r.cfg[PSC_SEL_HI:PSC_SEL_LO] == 3'h2) [*8]
                              |-> tick && !$past(tick) && !$past(tick, 4) && !$past(tick, 7))
    else $error("divide-by-8 tick spacing wrong");
  AST_TOGGLE_50: assert property (fast_pwm && toggle_mode && match[0] && action[0] == ACT_TOGGLE
                                  |=> o_compare_out_a_pin != $past(o_compare_out_a_pin))
    else $error("fast PWM toggle failed");
  AST_CMP_EVENT: assert property (match[0] |=> state_r.sts[STS_CMP_A])
    else $error("compare A event not flagged");
endmodule : timer_compare_output_pwm
`default_nettype wire

// ### hdl/timer_pwm_pkg.sv
// Constants for the timer compare-output and fast-PWM stage
package timer_pwm_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_OUTPUT_MODE_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CLOCK_CFG = 5'h04;
  localparam logic [4:0] ADDR_COMPARE_VALUE_A = 5'h08;
  localparam logic [4:0] ADDR_COMPARE_VALUE_B = 5'h0C;
  localparam logic [4:0] ADDR_COUNTER_VALUE = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h14;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h18;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAN_A_ACTION_HI = 7;
  localparam int ACTION_FIELD_STEP = 2;
  localparam int WGM_LO_HI = 1;
  localparam int WGM_HI_HI = 1;
  localparam int PSC_SEL_HI = 6;
  localparam int PSC_SEL_LO = 4;
  localparam int GATE_BIT = 7;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hF3;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hF3;
  localparam int STS_OVF = 0;
  localparam int STS_CMP_A = 1;
  localparam int IRQ_W = 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // ----------------------------------------------------------------
  // Output actions and waveform modes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_ALT = 4'hC;
  localparam logic [3:0] WGM_FAST_8 = 4'h5;
  localparam logic [3:0] WGM_FAST_9 = 4'h6;
  localparam logic [3:0] WGM_FAST_10 = 4'h7;
  localparam logic [3:0] WGM_FAST_FIXED = 4'hE;
  localparam logic [3:0] WGM_FAST_A = 4'hF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  // ----------------------------------------------------------------
  // Prescaler: last count of each division factor
  // ----------------------------------------------------------------
  localparam logic [9:0] PSC_LAST_1 = 10'h000;
  localparam logic [9:0] PSC_LAST_8 = 10'h007;
  localparam logic [9:0] PSC_LAST_32 = 10'h01F;
  localparam logic [9:0] PSC_LAST_64 = 10'h03F;
  localparam logic [9:0] PSC_LAST_128 = 10'h07F;
  localparam logic [9:0] PSC_LAST_256 = 10'h0FF;
  localparam logic [9:0] PSC_LAST_1024 = 10'h3FF;
endpackage : timer_pwm_pkg

// ### dv/pin_load_model.sv
// External load on one compare output pin, with the port pin direction bit
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
  input wire logic i_pin,
  input wire logic i_override,
  input wire logic i_dir_out,
  output logic o_pad
);
  // Pad shows the waveform only when the block owns the pin and the driver is on; else pull-up
  assign o_pad = (i_override && i_dir_out) ? i_pin : 1'b1;
endmodule : pin_load_model
`default_nettype wire

// ### dv/timer_compare_output_pwm_tb.sv
// Self-checking testbench of the timer compare-output and fast-PWM stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module timer_compare_output_pwm_tb
  import timer_pwm_pkg::*;
;
  logic i_core_clk;
  logic i_reset;
  logic [4:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic pa, oa, pb, ob, irq, dir_a, dir_b, pad_a, pad_b;
  int n_fail = 0;
  int compares = 0;
  int ha, hb, ca, cb, n, ex;
  logic [31:0] q;
  logic [7:0] ctrl;

  timer_compare_output_pwm u_timer_compare_output_pwm (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .o_compare_out_a_pin(pa), .o_compare_out_a_override(oa), .o_compare_out_b_pin(pb),
    .o_compare_out_b_override(ob), .o_irq(irq));
  pin_load_model u_load_a (.i_pin(pa), .i_override(oa), .i_dir_out(dir_a), .o_pad(pad_a));
  pin_load_model u_load_b (.i_pin(pb), .i_override(ob), .i_dir_out(dir_b), .o_pad(pad_b));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ----------------------------------------------------------------
  // Bus access, measurement and expectations
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    `CHK("waitrequest", 1'b0, wreq)
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask : rd_reg

  task automatic setup(input logic [7:0] c, input logic [1:0] wh, input logic [2:0] ps, input int a, input int b);
    wr_reg(ADDR_CLOCK_CFG, {30'h0, wh});
    wr_reg(ADDR_OUTPUT_MODE_CTRL, {24'h0, c});
    wr_reg(ADDR_COMPARE_VALUE_A, 32'(a));
    wr_reg(ADDR_COMPARE_VALUE_B, 32'(b));
    wr_reg(ADDR_COUNTER_VALUE, 32'h0);
    wr_reg(ADDR_CLOCK_CFG, {24'h0, 1'b0, ps, 2'b00, wh});
  endtask : setup

  task automatic measure(input int cyc);
    ha = 0;
    hb = 0;
    repeat (cyc) begin
      @(negedge i_core_clk);
      ha += int'(pad_a === 1'b1);
      hb += int'(pad_b === 1'b1);
    end
  endtask : measure

  function automatic int exp_high(input logic [1:0] code, input int c);
    return (code == ACT_CLEAR) ? c + 1 : 255 - c;
  endfunction : exp_high

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (50000) @(posedge i_core_clk);
    n_fail++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    dir_a = 1'b1;
    dir_b = 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_reset <= 1'b0;
    void'($urandom(82));
    @(posedge i_core_clk);
    for (int i = 0; i < 8; i++) begin
      rd_reg(5'(i * 4));
      `CHK("reset_value", 32'h0, q)
    end
    `CHK("override_a", 1'b0, oa)
    wr_reg(ADDR_OUTPUT_MODE_CTRL, 32'hFF);
    rd_reg(ADDR_OUTPUT_MODE_CTRL);
    `CHK("ctrl_readback", 32'hF3, q)
    setup(8'hB1, 2'b01, 3'h0, 10, 20);
    wr_reg(ADDR_CLOCK_CFG, 32'h91);
    repeat (20) @(posedge i_core_clk);
    rd_reg(ADDR_COUNTER_VALUE);
    `CHK("counter_gated", 32'h0, q)
    wr_reg(ADDR_CLOCK_CFG, 32'h11);
    repeat (20) @(posedge i_core_clk);
    rd_reg(ADDR_COUNTER_VALUE);
    `CHK("counter_runs", 1'b1, q[15:0] > 16'h0000 && q[15:0] < 16'h0100)
    for (int i = 0; i < 4; i++) begin
      ca = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(254, 1);
      cb = (i == 0) ? 255 : $urandom_range(254, 0);
      ctrl = i[0] ? 8'hE1 : 8'hB1;
      setup(ctrl, 2'b01, 3'h1, ca, cb);
      repeat (256) @(posedge i_core_clk);
      measure(256);
      `CHK("duty_a", exp_high(ctrl[7:6], ca), ha)
      `CHK("duty_b", exp_high(ctrl[5:4], cb), hb)
      `CHK("override_b", 1'b1, ob)
    end
    wr_reg(ADDR_IRQ_ENABLE, 32'h1);
    @(negedge i_core_clk);
    `CHK("irq_on", 1'b1, irq)
    rd_reg(ADDR_IRQ_STATUS);
    `CHK("status", 32'h7, q)
    wr_reg(ADDR_CLOCK_CFG, 32'h01);
    wr_reg(ADDR_IRQ_ENABLE, 32'h0);
    @(negedge i_core_clk);
    `CHK("irq_masked", 1'b0, irq)
    wr_reg(ADDR_IRQ_CLEAR, 32'h1);
    wr_reg(ADDR_IRQ_STATUS, 32'h0);
    rd_reg(ADDR_IRQ_STATUS);
    `CHK("status_cleared", 32'h6, q)
    wr_reg(ADDR_IRQ_ENABLE, 32'h7);
    @(negedge i_core_clk);
    `CHK("irq_compare", 1'b1, irq)
    wr_reg(ADDR_IRQ_CLEAR, 32'h6);
    @(negedge i_core_clk);
    `CHK("irq_off", 1'b0, irq)
    rd_reg(ADDR_IRQ_CLEAR);
    `CHK("clear_reads_zero", 32'h0, q)
    for (int ps = 1; ps < 4; ps++) begin
      n = (ps == 1) ? 1 : (ps == 2) ? 8 : 32;
      ca = $urandom_range(254, 0);
      setup(8'hB1, 2'b01, 3'(ps), ca, ca);
      repeat (256 * n) @(posedge i_core_clk);
      measure(256 * n);
      `CHK("prescaled_duty", (ca + 1) * n, ha)
    end
    ca = $urandom_range(100, 8);
    setup(8'h57, 2'b11, 3'h1, ca, ca / 2);
    repeat (2 * (ca + 1)) @(posedge i_core_clk);
    measure(4 * (ca + 1));
    `CHK("toggle_half", 2 * (ca + 1), ha)
    `CHK("override_b_mode15", 1'b0, ob)
    setup(8'h51, 2'b01, 3'h1, ca, ca);
    `CHK("override_a_mode5", 1'b0, oa)
    for (int code = 0; code < 4; code++) begin
      ca = $urandom_range(60, 8);
      setup({2'(code), 2'(code), 4'h0}, 2'b01, 3'h1, ca, ca / 2);
      repeat (2 * (ca + 1)) @(posedge i_core_clk);
      measure(2 * (ca + 1));
      ex = (code == 1) ? ca + 1 : (code == 2) ? 0 : 2 * (ca + 1);
      `CHK("ctc_a", ex, ha)
      `CHK("ctc_b", ex, hb)
      `CHK("ctc_override", code != 0, oa)
      if (code == 2) begin
        @(posedge i_core_clk);
        dir_a <= 1'b0;
        measure(8);
        `CHK("pad_dir_in", 8, ha)
        @(posedge i_core_clk);
        dir_a <= 1'b1;
      end
    end
    give_verdict();
  end
endmodule : timer_compare_output_pwm_tb
`default_nettype wire
